// *** logic/lem_regs.svh ***
// register offsets, field positions, reset values of the emulation-mode control block
// assumes a 32-bit aligned AXI4-Lite register map
`ifndef LEM_REGS_SVH
`define LEM_REGS_SVH

`define LEM_ADDR_W      4
`define LEM_OFS_FLAGS   4'h0
`define LEM_OFS_CTRL4   4'h4
`define LEM_OFS_STATUS  4'h8

`define LEM_FLAGS_VM    17
`define LEM_FLAGS_NT    14
`define LEM_FLAGS_IO_PRIVILEGE_LEVEL_LO 12
`define LEM_FLAGS_IO_PRIVILEGE_LEVEL_HI 13
`define LEM_CTRL4_MEXT  0

`define LEM_FLAGS_RST   32'h0000_0002
`define LEM_CTRL4_RST   32'h0000_0000
`define LEM_CTRL4_MASK  32'h0000_0001

`define LEM_CPL_USER    2'h3
`define LEM_IO_PRIVILEGE_LEVEL_MAX    2'h3
`define LEM_SEG_SHIFT   4

`define LEM_RESP_OKAY   2'h0
`define LEM_RESP_SLVERR 2'h2

`endif

// *** logic/lem_pkg.sv ***
// types shared by the emulation-mode control block
// assumes lem_regs.svh for offsets and field positions
package lem_pkg;
    typedef enum logic [3:0] {
        LEM_INSN_OTHER,
        LEM_INSN_HALT,
        LEM_INSN_IRQ_CLR,
        LEM_INSN_IRQ_SET,
        LEM_INSN_FLAGS_PUSH,
        LEM_INSN_FLAGS_POP,
        LEM_INSN_SOFT_INT,
        LEM_INSN_INTERRUPT_RETURN,
        LEM_INSN_PORT_IO
    } lem_insn_e;

    typedef logic [31:0] lem_word_t;
    typedef logic [1:0]  lem_priv_t;
endpackage

// *** logic/lem_mode_ctrl.sv ***
// emulation-mode control: mode flag tracking, privilege, address forming and sensitive-insn traps
// assumes one 125 MHz clock, synchronous active-low reset, core events as one-cycle pulses
// Functional notes
// - the emulation mode is active exactly while the virtual machine flag is set
// - the flag is set only by a task switch or an interrupt return
// - flag pops and software writes of the flags register keep the mode flag
// - while emulating, current privilege level is always 3
// - the flag steers segment loads, instruction decode and permission checks
// - a task switch to a 16-bit task state segment clears the flag
// - the flag is updated before segment loads; set means real-style bases
// - call, jump or nested interrupt return task switch enters mode from image
// - handler return enters the mode when the popped image has the flag
// - interrupts, exceptions, reset, warm start, a task switch or a handler return without the flag leave the mode
// - a task switch out loads flags from the new task image
// - exceptions go to protected handlers; return or task switch may follow
// - reset or warm start leaves the mode and enters real-address mode
// - halt in emulation mode raises a general protection fault
// - irq set/clear, flag push/pop, soft int, interrupt_return fault when io level below 3
// - port transfers skip the io privilege check in emulation mode
// - 21-bit emulation addresses are zero-extended to 32 bits before paging
// - emulation addresses stay within the first 1 MByte plus 64 KBytes
// - supervisor pages are refused to code in the emulation mode
// - with mode extensions on, soft interrupts are redirected inside the mode
// - io privilege level sits at flags bits 12 and 13
// - mode extension enable sits at bit 0 of control register four
`include "lem_regs.svh"

module lem_mode_ctrl (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      warm_start_pin,
    input  wire logic                      task_switch_valid,
    input  wire logic                      task_switch_tss32,
    input  wire lem_pkg::lem_word_t        task_switch_flags,
    input  wire logic                      handler_return_valid,
    input  wire lem_pkg::lem_word_t        handler_return_flags,
    input  wire logic                      flags_pop_valid,
    input  wire lem_pkg::lem_word_t        flags_pop_data,
    input  wire logic                      event_taken,
    input  wire lem_pkg::lem_priv_t        prot_priv_level,
    input  wire logic                      insn_valid,
    input  wire lem_pkg::lem_insn_e        insn_class,
    input  wire logic                      seg_load_valid,
    input  wire logic [15:0]               seg_selector,
    input  wire logic [15:0]               seg_offset,
    input  wire lem_pkg::lem_word_t        seg_desc_base,
    input  wire logic                      page_check_valid,
    input  wire logic                      page_user_supervisor_bit,
    output logic                           emulation_mode,
    output lem_pkg::lem_priv_t             current_privilege_level,
    output logic                           general_protection_fault,
    output logic                           halt_granted,
    output logic                           io_check_needed,
    output logic                           soft_int_redirect,
    output logic                           linear_valid,
    output lem_pkg::lem_word_t             linear_addr,
    output logic                           page_denied,
    input  wire logic [`LEM_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [`LEM_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import lem_pkg::*;

    lem_word_t              flags_register_ff;
    lem_word_t              nxt_flags;
    lem_word_t              control_register_four_ff;
    logic                   vm_now;
    logic                   nxt_vm;
    logic                   io_privilege_level_low;
    logic                   mext_en;
    logic                   gp_fault_ff;
    logic                   halt_ok_ff;
    logic                   io_check_ff;
    logic                   redirect_ff;
    logic                   lin_valid_ff;
    lem_word_t              lin_addr_ff;
    logic                   page_denied_ff;
    logic [7:0]             gp_count_ff;
    logic                   aw_held_ff;
    logic [`LEM_ADDR_W-1:0] awaddr_ff;
    logic                   w_held_ff;
    logic [31:0]            wdata_ff;
    logic [3:0]             wstrb_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic                   rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;
    logic                   wr_fire;
    logic                   rd_fire;
    logic                   bus_flags_wr;
    logic                   bus_ctrl4_wr;
    logic [20:0]            real_sum;

    function automatic lem_word_t merge_bytes(input lem_word_t old_v, input lem_word_t new_v,
                                              input logic [3:0] strb);
        lem_word_t res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign vm_now   = flags_register_ff[`LEM_FLAGS_VM];
    assign io_privilege_level_low = flags_register_ff[`LEM_FLAGS_IO_PRIVILEGE_LEVEL_HI:`LEM_FLAGS_IO_PRIVILEGE_LEVEL_LO] != `LEM_IO_PRIVILEGE_LEVEL_MAX;
    assign mext_en  = control_register_four_ff[`LEM_CTRL4_MEXT];

    // bus register write handshakes
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
    assign bus_flags_wr  = wr_fire && awaddr_ff == `LEM_OFS_FLAGS;
    assign bus_ctrl4_wr  = wr_fire && awaddr_ff == `LEM_OFS_CTRL4;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign rd_fire       = s_axi_arvalid && !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // flag image update; warm start and taken events outrank task switches and handler returns, so an event in the same cycle always leaves the mode
    always_comb begin
        nxt_flags = flags_register_ff;
        if (warm_start_pin) begin
            nxt_flags = `LEM_FLAGS_RST;
        end else if (event_taken) begin
            nxt_flags[`LEM_FLAGS_VM] = 1'b0;
        end else if (task_switch_valid) begin
            nxt_flags = task_switch_flags;
            if (!task_switch_tss32) begin
                nxt_flags[31:16] = 16'h0000;
            end
        end else if (handler_return_valid) begin
            nxt_flags = handler_return_flags;
        end else if (flags_pop_valid) begin
            nxt_flags = flags_pop_data;
            nxt_flags[`LEM_FLAGS_VM] = flags_register_ff[`LEM_FLAGS_VM];
        end else if (bus_flags_wr) begin
            nxt_flags = merge_bytes(flags_register_ff, wdata_ff, wstrb_ff);
            nxt_flags[`LEM_FLAGS_VM] = flags_register_ff[`LEM_FLAGS_VM];
        end
    end
    assign nxt_vm = nxt_flags[`LEM_FLAGS_VM];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_register_ff <= `LEM_FLAGS_RST;
        end else begin
            flags_register_ff <= nxt_flags;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_register_four_ff <= `LEM_CTRL4_RST;
        end else if (bus_ctrl4_wr) begin
            control_register_four_ff <= merge_bytes(control_register_four_ff, wdata_ff, wstrb_ff)
                                        & `LEM_CTRL4_MASK;
        end
    end

    // decode checks use the current mode; a trap is a single-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gp_fault_ff <= 1'b0;
            halt_ok_ff  <= 1'b0;
            io_check_ff <= 1'b0;
            redirect_ff <= 1'b0;
        end else begin
            gp_fault_ff <= 1'b0;
            halt_ok_ff  <= 1'b0;
            io_check_ff <= 1'b0;
            redirect_ff <= 1'b0;
            if (insn_valid) begin
                case (insn_class)
                    LEM_INSN_HALT: begin
                        gp_fault_ff <= vm_now;
                        halt_ok_ff  <= !vm_now;
                    end
                    LEM_INSN_SOFT_INT: begin
                        // redirection bypasses the trap so the program's own handler runs
                        redirect_ff <= vm_now && mext_en;
                        gp_fault_ff <= vm_now && !mext_en && io_privilege_level_low;
                    end
                    LEM_INSN_IRQ_CLR, LEM_INSN_IRQ_SET, LEM_INSN_FLAGS_PUSH,
                    LEM_INSN_FLAGS_POP, LEM_INSN_INTERRUPT_RETURN: begin
                        gp_fault_ff <= vm_now && io_privilege_level_low;
                    end
                    LEM_INSN_PORT_IO: begin
                        io_check_ff <= !vm_now;
                    end
                    default: begin
                        gp_fault_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gp_count_ff <= 8'h00;
        end else if (gp_fault_ff) begin
            gp_count_ff <= gp_count_ff + 8'h01;
        end
    end

    // segment forming sees the flag as updated this cycle, so a task switch's own loads
    // already use the new translation style
    assign real_sum = {1'b0, seg_selector, 4'h0} + {5'h00, seg_offset};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lin_valid_ff <= 1'b0;
            lin_addr_ff  <= 32'h0000_0000;
        end else begin
            lin_valid_ff <= seg_load_valid;
            if (seg_load_valid) begin
                if (nxt_vm) begin
                    lin_addr_ff <= {11'h000, real_sum};
                end else begin
                    lin_addr_ff <= seg_desc_base + {16'h0000, seg_offset};
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_denied_ff <= 1'b0;
        end else begin
            page_denied_ff <= page_check_valid && vm_now && !page_user_supervisor_bit;
        end
    end

    assign emulation_mode           = vm_now;
    assign current_privilege_level  = vm_now ? `LEM_CPL_USER : prot_priv_level;
    assign general_protection_fault = gp_fault_ff;
    assign halt_granted             = halt_ok_ff;
    assign io_check_needed          = io_check_ff;
    assign soft_int_redirect        = redirect_ff;
    assign linear_valid             = lin_valid_ff;
    assign linear_addr              = lin_addr_ff;
    assign page_denied              = page_denied_ff;

    // write channels are accepted in either order and answered once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_held_ff  <= 1'b0;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `LEM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= (bus_flags_wr || bus_ctrl4_wr) ? `LEM_RESP_OKAY : `LEM_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `LEM_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= `LEM_RESP_OKAY;
            case (s_axi_araddr)
                `LEM_OFS_FLAGS:  rdata_ff <= flags_register_ff;
                `LEM_OFS_CTRL4:  rdata_ff <= control_register_four_ff;
                `LEM_OFS_STATUS: rdata_ff <= {16'h0000, gp_count_ff, 5'h00,
                                              current_privilege_level, vm_now};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= `LEM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

// *** dv/lem_mode_ctrl_asserts.sv ***
// checker of the emulation-mode control block, watching its top-level ports only
// assumes one clock domain, synchronous active-low reset and one-cycle event pulses
module lem_mode_ctrl_chk (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               warm_start_pin,
    input wire logic               task_switch_valid,
    input wire logic               task_switch_tss32,
    input wire lem_pkg::lem_word_t task_switch_flags,
    input wire logic               handler_return_valid,
    input wire lem_pkg::lem_word_t handler_return_flags,
    input wire logic               flags_pop_valid,
    input wire logic               event_taken,
    input wire logic               insn_valid,
    input wire lem_pkg::lem_insn_e insn_class,
    input wire logic               seg_load_valid,
    input wire logic [15:0]        seg_selector,
    input wire logic [15:0]        seg_offset,
    input wire logic               page_check_valid,
    input wire logic               page_user_supervisor_bit,
    input wire logic               emulation_mode,
    input wire lem_pkg::lem_priv_t current_privilege_level,
    input wire logic               general_protection_fault,
    input wire logic               io_check_needed,
    input wire lem_pkg::lem_word_t linear_addr,
    input wire logic               page_denied
);
    timeunit 1ns;
    timeprecision 1ps;
    import lem_pkg::*;
    // events of higher priority hide the lower ones, so each check of an update rules out the events that outrank it
    logic hw_evt;
    logic any_evt;
    logic set_cause;
    assign hw_evt    = warm_start_pin | event_taken;
    assign any_evt   = hw_evt | task_switch_valid | handler_return_valid;
    assign set_cause = (task_switch_valid & task_switch_tss32) | handler_return_valid;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_cpl_user_emul: assert property (emulation_mode |-> current_privilege_level == 2'h3)
        else $error("privilege level not user while emulating");
    a_pop_keeps_mode: assert property (flags_pop_valid && !any_evt |=> $stable(emulation_mode))
        else $error("flag pop changed the mode flag");
    a_tss16_clears: assert property (task_switch_valid && !task_switch_tss32 && !hw_evt |=> !emulation_mode)
        else $error("short task image left the mode set");
    a_tss32_loads: assert property (task_switch_valid && task_switch_tss32 && !hw_evt
        |=> emulation_mode == $past(task_switch_flags[17]))
        else $error("task switch did not load the mode flag");
    a_ret_loads: assert property (handler_return_valid && !hw_evt && !task_switch_valid
        |=> emulation_mode == $past(handler_return_flags[17]))
        else $error("handler return did not load the mode flag");
    a_event_leaves: assert property (hw_evt |=> !emulation_mode)
        else $error("event did not leave the mode");
    a_set_only_cause: assert property ($rose(emulation_mode) |-> $past(set_cause))
        else $error("mode set without a task switch or return");
    a_halt_faults: assert property (insn_valid && emulation_mode && insn_class == LEM_INSN_HALT
        |=> general_protection_fault)
        else $error("halt in emulation did not fault");
    a_port_no_check: assert property (insn_valid && emulation_mode && insn_class == LEM_INSN_PORT_IO
        |=> !general_protection_fault && !io_check_needed)
        else $error("port transfer checked in emulation");
    a_real_linear: assert property (seg_load_valid && emulation_mode && !any_evt
        |=> linear_addr == {12'h000, $past(seg_selector), 4'h0} + {16'h0000, $past(seg_offset)}
        && linear_addr < 32'h0011_0000)
        else $error("emulation linear address wrong");
    a_super_denied: assert property (page_check_valid && emulation_mode && !any_evt
        && !page_user_supervisor_bit |=> page_denied)
        else $error("supervisor page reached from emulation");
    c_enter: cover property (task_switch_valid ##1 emulation_mode);
    c_fault: cover property (general_protection_fault);
    c_return: cover property (handler_return_valid ##1 emulation_mode);
endmodule

bind lem_mode_ctrl lem_mode_ctrl_chk i_chk (.*);

// *** dv/lem_mode_ctrl_tb_top.sv ***
// self-checking bench of the emulation-mode control block
// assumes lem_pkg and lem_regs.svh compiled ahead; the bench drives every port itself
`include "lem_regs.svh"
module lem_mode_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lem_pkg::*;
    logic        aclk, aresetn, warm_start_pin, task_switch_valid, task_switch_tss32, handler_return_valid;
    logic        flags_pop_valid, event_taken, insn_valid, seg_load_valid, page_check_valid, page_user_supervisor_bit;
    logic        emulation_mode, general_protection_fault, halt_granted, io_check_needed, soft_int_redirect;
    logic        linear_valid, page_denied, mext;
    lem_word_t   task_switch_flags, handler_return_flags, flags_pop_data, seg_desc_base, linear_addr;
    lem_priv_t   prot_priv_level, current_privilege_level, io_privilege_level;
    lem_insn_e   insn_class;
    logic [15:0] seg_selector, seg_offset;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          fails, compares, cyc, gps;
    lem_mode_ctrl i_dut (.*);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // a hang in any handshake ends here rather than stalling the run
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            summarize();
        end
    end
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // pulses are taken at the next edge; registered answers are looked at just after it
    task automatic step();
        @(posedge aclk);
        {warm_start_pin, task_switch_valid, handler_return_valid, flags_pop_valid} <= 4'h0;
        {event_taken, insn_valid, seg_load_valid, page_check_valid} <= 4'h0;
        #1;
    endtask
    task automatic tsw(input logic t32, input lem_word_t f);
        @(posedge aclk);
        task_switch_valid <= 1'b1;
        task_switch_tss32 <= t32;
        task_switch_flags <= f;
        step();
    endtask
    task automatic insn(input lem_insn_e c);
        @(posedge aclk);
        insn_valid <= 1'b1;
        insn_class <= c;
        step();
    endtask
    function automatic logic exp_gp(lem_insn_e c, lem_priv_t l, logic x);
        case (c)
            LEM_INSN_HALT: exp_gp = 1'b1;
            LEM_INSN_SOFT_INT: exp_gp = (l != 2'h3) && !x;
            LEM_INSN_IRQ_CLR, LEM_INSN_IRQ_SET, LEM_INSN_FLAGS_PUSH, LEM_INSN_FLAGS_POP, LEM_INSN_INTERRUPT_RETURN: exp_gp = l != 2'h3;
            default: exp_gp = 1'b0;
        endcase
    endfunction
    initial begin
        {aresetn, warm_start_pin, task_switch_valid, task_switch_tss32, handler_return_valid} = 5'h00;
        {flags_pop_valid, event_taken, insn_valid, seg_load_valid, page_check_valid, page_user_supervisor_bit} = 6'h00;
        {task_switch_flags, handler_return_flags, flags_pop_data, seg_desc_base} = 128'h0;
        {seg_selector, seg_offset, prot_priv_level, s_axi_awaddr, s_axi_araddr} = 42'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wdata} = 37'h0;
        insn_class = LEM_INSN_OTHER;
        s_axi_wstrb = 4'hf;
        cyc = 0;
        void'($urandom(92));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`LEM_OFS_FLAGS);
        chk(rd, `LEM_FLAGS_RST);
        axr(`LEM_OFS_CTRL4);
        chk(rd, `LEM_CTRL4_RST);
        axw(`LEM_OFS_FLAGS, 32'h0002_3002);
        axr(`LEM_OFS_FLAGS);
        chk({rd[17], rd[13:12]}, 3'b011);
        axw(`LEM_OFS_STATUS, 32'h0000_0001);
        chk(rs, `LEM_RESP_SLVERR);
        axr(4'hc);
        chk(rs, `LEM_RESP_SLVERR);
        @(posedge aclk);
        flags_pop_valid <= 1'b1;
        flags_pop_data <= 32'h0002_0000 | $urandom;
        step();
        chk(emulation_mode, 1'b0);
        tsw(1'b0, 32'h0002_3002);
        chk(emulation_mode, 1'b0);
        insn(LEM_INSN_HALT);
        chk({halt_granted, general_protection_fault}, 2'b10);
        insn(LEM_INSN_PORT_IO);
        chk(io_check_needed, 1'b1);
        $display("test reset and refusals done");
        for (int i = 0; i < 40; i++) begin
            io_privilege_level = lem_priv_t'($urandom);
            mext = (i < 2) ? i[0] : 1'($urandom);
            prot_priv_level <= lem_priv_t'($urandom);
            axw(`LEM_OFS_CTRL4, {31'h0, mext});
            tsw(1'b1, 32'h0002_0002 | {18'h0, io_privilege_level, 12'h000});
            chk(emulation_mode, 1'b1);
            chk(current_privilege_level, `LEM_CPL_USER);
            for (int c = 0; c < 9; c++) begin
                insn(lem_insn_e'(c));
                chk(general_protection_fault, exp_gp(lem_insn_e'(c), io_privilege_level, mext));
                chk(soft_int_redirect, c == LEM_INSN_SOFT_INT && mext);
                chk({halt_granted, io_check_needed}, 2'b00);
                gps += exp_gp(lem_insn_e'(c), io_privilege_level, mext);
            end
            @(posedge aclk);
            seg_load_valid <= 1'b1;
            seg_selector <= (i == 0) ? 16'hffff : 16'($urandom);
            seg_offset <= (i == 0) ? 16'hffff : 16'($urandom);
            page_check_valid <= 1'b1;
            page_user_supervisor_bit <= i[0];
            step();
            chk(linear_addr, {12'h000, seg_selector, 4'h0} + {16'h0000, seg_offset});
            chk(page_denied, !i[0]);
            chk(linear_valid, 1'b1);
            @(posedge aclk);
            case (i % 3)
                0: event_taken <= 1'b1;
                1: warm_start_pin <= 1'b1;
                default: begin
                    task_switch_valid <= 1'b1;
                    task_switch_flags <= 32'h0000_0002;
                end
            endcase
            step();
            chk(emulation_mode, 1'b0);
            chk(current_privilege_level, prot_priv_level);
            if (i % 3 == 1) begin
                axr(`LEM_OFS_FLAGS);
                chk(rd, `LEM_FLAGS_RST);
            end
            @(posedge aclk);
            seg_load_valid <= 1'b1;
            seg_desc_base <= $urandom;
            step();
            chk(linear_addr, seg_desc_base + {16'h0000, seg_offset});
            @(posedge aclk);
            handler_return_valid <= 1'b1;
            handler_return_flags <= {14'h0, i[1], 17'h0_0002};
            step();
            chk(emulation_mode, i[1]);
            @(posedge aclk);
            event_taken <= 1'b1;
            step();
        end
        // fault count wraps at eight bits, as the status word holds it
        axr(`LEM_OFS_STATUS);
        chk(rd, {16'h0000, 8'(gps), 5'h00, prot_priv_level, 1'b0});
        $display("test mode entry and traps done");
        summarize();
    end
endmodule
